// *** src/uefc_ep_config_regs.sv ***
// What this block does
// - endpoint answers traffic only while enabled; direction bit 0 is OUT, 1 is IN
// - type field bits 5:4: invalid, isochronous, bulk default, interrupt
// - buffering field: 00 quad, 01 invalid, others double or triple
// - four 8-bit fifo configuration registers at indices E618 to E61B
// - empty-packet bit plus packet-end on empty IN packet of an enabled endpoint sends zero-length
// - per-endpoint 16-bit select; their OR turns upper port into data lines
`timescale 1ns/1ps
`default_nettype none
module uefc_ep_config_regs (
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [uefc_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic [uefc_pkg::DATA_W-1:0] pwdata, // apb write data
    output logic [uefc_pkg::DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [3:0] usb_traffic, // token addressed to endpoint
    output logic [3:0] ep_respond, // endpoint answers the token
    output logic [3:0] ep_enable, // endpoint enabled
    output logic [3:0] ep_dir_in, // 1 = IN, 0 = OUT
    output logic [7:0] ep_type, // two type bits per endpoint
    output logic [3:0] ep_type_invalid, // type code 00
    output logic [3:0] ep_buf_1024, // effective buffer is 1024 bytes
    output logic [11:0] ep_buf_count, // three bits of depth per endpoint
    output logic [3:0] ep_buf_invalid, // buffering code 01
    output logic [3:0] in_full_early_flag, // early full flag select
    output logic [3:0] out_empty_early_flag, // early empty flag select
    output logic [3:0] auto_commit_out, // auto commit of OUT packets
    output logic [3:0] auto_commit_in, // auto commit of IN packets
    output logic [3:0] empty_packet_enable, // zero-length IN enable
    output logic [3:0] sixteen_bit_select, // word-wide transfers
    input wire logic [3:0] packet_end_strobe, // pin, per endpoint
    input wire logic [3:0] in_pkt_empty, // current IN packet holds no bytes
    output logic [3:0] send_empty_packet, // one-cycle zero-length request
    output logic upper_port_is_fifo_data // upper port pins carry data
);
    // ======================================================
    // declarations
    logic [7:0] setup_reg [4];
    logic [7:0] fifo_reg [4];
    logic [uefc_pkg::DATA_W-1:0] prdata_reg;
    logic [3:0] send_empty_reg;
    logic upper_fifo_reg;
    logic reg_is_fifo;
    logic [1:0] reg_ep;
    logic wr_pulse;
    logic rd_setup;
    logic [3:0] pend_pulse;

    // endpoints 4 and 8 have no size bit
    function automatic logic [7:0] setup_mask(input int ep);
        setup_mask = ep[0] ? uefc_pkg::SETUP_WMASK_512
                           : uefc_pkg::SETUP_WMASK;
    endfunction : setup_mask

    function automatic logic [2:0] buf_depth(input logic [1:0] code);
        unique case (uefc_pkg::uefc_buf_t'(code))
            uefc_pkg::UEFC_BUF_QUAD: buf_depth = uefc_pkg::DEPTH_QUAD;
            uefc_pkg::UEFC_BUF_DOUBLE: buf_depth = uefc_pkg::DEPTH_DOUBLE;
            uefc_pkg::UEFC_BUF_TRIPLE: buf_depth = uefc_pkg::DEPTH_TRIPLE;
            uefc_pkg::UEFC_BUF_INVALID: buf_depth = uefc_pkg::DEPTH_NONE;
        endcase
    endfunction : buf_depth

    // ======================================================
    // bus slave
    uefc_apb_decode u_dec (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .reg_is_fifo(reg_is_fifo),
        .reg_ep(reg_ep),
        .wr_pulse(wr_pulse),
        .rd_setup(rd_setup)
    );

    // read data is captured in the setup phase, stable in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (rd_setup)
            prdata_reg <= {24'h0, reg_is_fifo ? fifo_reg[reg_ep]
                                             : setup_reg[reg_ep]};
    end
    assign prdata = prdata_reg;

    // ======================================================
    // endpoint setup registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                setup_reg[i] <= uefc_pkg::SETUP_RST & setup_mask(i);
        end
        else if (wr_pulse && !reg_is_fifo)
        begin
            for (int i = 0; i < 4; i++)
                if (reg_ep == i[1:0])
                    setup_reg[i] <= pwdata[7:0] & setup_mask(i);
        end
    end

    // ======================================================
    // fifo configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
                fifo_reg[i] <= uefc_pkg::FIFO_RST;
        end
        else if (wr_pulse && reg_is_fifo)
        begin
            for (int i = 0; i < 4; i++)
                if (reg_ep == i[1:0])
                    fifo_reg[i] <= pwdata[7:0] & uefc_pkg::FIFO_WMASK;
        end
    end

    // ======================================================
    // decoded configuration outputs
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ep_enable[i] = setup_reg[i][uefc_pkg::SETUP_VALID_BIT];
            ep_dir_in[i] = setup_reg[i][uefc_pkg::SETUP_DIR_BIT];
            ep_type[2*i +: 2] =
                setup_reg[i][uefc_pkg::SETUP_TYPE_LO +: 2];
            ep_type_invalid[i] = (ep_type[2*i +: 2]
                == uefc_pkg::UEFC_TYPE_INVALID);
            ep_buf_1024[i] = setup_reg[i][uefc_pkg::SETUP_SIZE_BIT]
                && !i[0];
            ep_buf_count[3*i +: 3] =
                buf_depth(setup_reg[i][uefc_pkg::SETUP_BUF_LO +: 2]);
            ep_buf_invalid[i] = (setup_reg[i][uefc_pkg::SETUP_BUF_LO +: 2]
                == uefc_pkg::UEFC_BUF_INVALID);
            in_full_early_flag[i] = fifo_reg[i][uefc_pkg::FIFO_IN_EARLY_BIT];
            out_empty_early_flag[i] =
                fifo_reg[i][uefc_pkg::FIFO_OUT_EARLY_BIT];
            auto_commit_out[i] = fifo_reg[i][uefc_pkg::FIFO_AUTO_OUT_BIT];
            auto_commit_in[i] = fifo_reg[i][uefc_pkg::FIFO_AUTO_IN_BIT];
            empty_packet_enable[i] =
                fifo_reg[i][uefc_pkg::FIFO_EMPTY_PKT_BIT];
            sixteen_bit_select[i] =
                fifo_reg[i][uefc_pkg::FIFO_WIDE_BIT];
        end
    end

    // disabled endpoints ignore every token
    assign ep_respond = usb_traffic & ep_enable;

    // ======================================================
    // packet end and zero-length packets
    uefc_edge_sync u_pend (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(packet_end_strobe),
        .rise_pulse(pend_pulse)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            send_empty_reg <= '0;
        else
            send_empty_reg <= pend_pulse & in_pkt_empty & ep_enable
                & ep_dir_in & empty_packet_enable;
    end
    assign send_empty_packet = send_empty_reg;

    // ======================================================
    // upper port pin function
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            upper_fifo_reg <= 1'b1;
        else
            upper_fifo_reg <= |sixteen_bit_select;
    end
    assign upper_port_is_fifo_data = upper_fifo_reg;

    // ======================================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_setup0;
    logic wr_setup1;
    logic wr_fifo2;
    logic rd_fifo_acc;
    assign wr_setup0 = wr_pulse && !reg_is_fifo && reg_ep == 2'h0;
    assign wr_setup1 = wr_pulse && !reg_is_fifo && reg_ep == 2'h1;
    assign wr_fifo2 = wr_pulse && paddr[19:2] == uefc_pkg::IDX_EP6_FIFO;
    assign rd_fifo_acc = psel && penable && !pwrite && reg_is_fifo
        && paddr[1:0] == 2'h0;

    chk_valid_write: assert property (
        wr_setup0 |=> ep_enable[0] == $past(pwdata[7])
            && ep_dir_in[0] == $past(pwdata[6]))
        else $error("enable or direction not taken from write");

    chk_respond_gate: assert property (
        wr_setup0 && !pwdata[7] ##1 usb_traffic[0] |-> !ep_respond[0])
        else $error("disabled endpoint answered traffic");

    chk_type_decode: assert property (
        wr_setup0 |=> ep_type[1:0] == $past(pwdata[5:4])
            && ep_type_invalid[0] == ($past(pwdata[5:4]) == 2'h0))
        else $error("type field decoded wrongly");

    chk_buf_depth: assert property (
        wr_setup0 && pwdata[1:0] == 2'h0 |=>
            ep_buf_count[2:0] == 3'h4 && !ep_buf_invalid[0])
        else $error("code 00 did not give four buffers");

    chk_buf_invalid: assert property (
        wr_setup0 && pwdata[1:0] == 2'h1 |=> ep_buf_invalid[0])
        else $error("code 01 not flagged invalid");

    chk_fifo_map: assert property (
        wr_fifo2 |=> sixteen_bit_select[2] == $past(pwdata[0])
            && empty_packet_enable[2] == $past(pwdata[2]))
        else $error("third fifo register not written");

    chk_fifo_rsvd: assert property (
        rd_fifo_acc |-> prdata[7] == 1'b0 && prdata[1] == 1'b0
            && prdata[31:8] == 24'h0)
        else $error("reserved fifo bits read nonzero");

    chk_size_fixed: assert property (
        wr_setup1 && pwdata[3] |=> ##[0:3] !ep_buf_1024[1]
            && !ep_buf_1024[3])
        else $error("second endpoint took 1024 bytes");

    chk_zero_len: assert property (
        pend_pulse[0] && in_pkt_empty[0] && ep_enable[0] && ep_dir_in[0]
            |-> ##1 send_empty_packet[0] == $past(empty_packet_enable[0]))
        else $error("zero-length packet decision wrong");

    chk_no_stray: assert property (
        send_empty_packet[0] |-> $past(pend_pulse[0])
            && $past(empty_packet_enable[0]))
        else $error("zero-length packet without cause");

    chk_wide_or: assert property (
        wr_fifo2 && pwdata[0] |=> ##1 upper_port_is_fifo_data)
        else $error("word width did not claim upper port");

    // ======================================================
    // invariants checked on every cycle
    chk_respond_all: assert property (
        ep_respond == (usb_traffic & ep_enable))
        else $error("endpoint response not gated by enable");

    chk_fixed_512: assert property (
        !ep_buf_1024[1] && !ep_buf_1024[3])
        else $error("fixed-size endpoint reports 1024 bytes");

    chk_upper_follow: assert property (
        upper_port_is_fifo_data == $past(|sixteen_bit_select))
        else $error("upper port does not follow word width");

    chk_type_ep8: assert property (
        ep_type_invalid[3] == (ep_type[7:6] == 2'h0))
        else $error("last endpoint type decode wrong");

    chk_rd_upper_zero: assert property (
        prdata[31:8] == 24'h0)
        else $error("read data upper bits nonzero");

    chk_zero_in_only: assert property (
        send_empty_packet[1] |-> $past(ep_enable[1] && ep_dir_in[1]))
        else $error("zero-length packet on OUT or disabled endpoint");

    chk_zero_ep8: assert property (
        send_empty_packet[3] |-> $past(pend_pulse[3])
            && $past(empty_packet_enable[3]))
        else $error("last endpoint sent zero-length without cause");

    chk_err_phase: assert property (
        pslverr |-> psel && penable)
        else $error("bus error outside access phase");

    cov_setup_write: cover property (wr_setup0 ##1 ep_enable[0]);
    cov_fifo_read: cover property (rd_fifo_acc);
    cov_empty_pkt: cover property (send_empty_packet[0]);
    cov_bad_addr: cover property (pslverr);
endmodule : uefc_ep_config_regs
`default_nettype wire

// *** inc/uefc_pkg.sv ***
`default_nettype none
// ==========================================================
// shared constants for the endpoint configuration bank
package uefc_pkg;
    localparam int NUM_EP = 4;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    // ======================================================
    // register indices; byte address is four times the index
    localparam logic [17:0] IDX_SETUP_BASE = 18'h0E610;
    localparam logic [17:0] IDX_FIFO_BASE = 18'h0E618;
    localparam logic [17:0] IDX_EP2_FIFO = 18'h0E618;
    localparam logic [17:0] IDX_EP4_FIFO = 18'h0E619;
    localparam logic [17:0] IDX_EP6_FIFO = 18'h0E61A;
    localparam logic [17:0] IDX_EP8_FIFO = 18'h0E61B;
    // ======================================================
    // endpoint setup fields
    localparam int SETUP_VALID_BIT = 7;
    localparam int SETUP_DIR_BIT = 6;
    localparam int SETUP_TYPE_LO = 4;
    localparam int SETUP_SIZE_BIT = 3;
    localparam int SETUP_BUF_LO = 0;
    localparam logic [7:0] SETUP_WMASK = 8'hFB;
    localparam logic [7:0] SETUP_WMASK_512 = 8'hF3;
    localparam logic [7:0] SETUP_RST = 8'hA2;
    // ======================================================
    // fifo configuration fields
    localparam int FIFO_IN_EARLY_BIT = 6;
    localparam int FIFO_OUT_EARLY_BIT = 5;
    localparam int FIFO_AUTO_OUT_BIT = 4;
    localparam int FIFO_AUTO_IN_BIT = 3;
    localparam int FIFO_EMPTY_PKT_BIT = 2;
    localparam int FIFO_WIDE_BIT = 0;
    localparam logic [7:0] FIFO_WMASK = 8'h7D;
    localparam logic [7:0] FIFO_RST = 8'h05;
    // ======================================================
    // transfer types and buffering depths
    typedef enum logic [1:0] {
        UEFC_TYPE_INVALID = 2'h0,
        UEFC_TYPE_ISO = 2'h1,
        UEFC_TYPE_BULK = 2'h2,
        UEFC_TYPE_INTR = 2'h3
    } uefc_ep_type_t;
    typedef enum logic [1:0] {
        UEFC_BUF_QUAD = 2'h0,
        UEFC_BUF_INVALID = 2'h1,
        UEFC_BUF_DOUBLE = 2'h2,
        UEFC_BUF_TRIPLE = 2'h3
    } uefc_buf_t;
    localparam logic [2:0] DEPTH_QUAD = 3'h4;
    localparam logic [2:0] DEPTH_TRIPLE = 3'h3;
    localparam logic [2:0] DEPTH_DOUBLE = 3'h2;
    localparam logic [2:0] DEPTH_NONE = 3'h0;
endpackage : uefc_pkg
`default_nettype wire

// *** src/uefc_apb_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// apb address decode, zero wait states, error on unmapped
module uefc_apb_decode (
    input wire logic psel, // slave select
    input wire logic penable, // access phase
    input wire logic pwrite, // write direction
    input wire logic [uefc_pkg::ADDR_W-1:0] paddr, // byte address
    output logic pready, // always ready
    output logic pslverr, // unmapped access
    output logic reg_is_fifo, // fifo config group selected
    output logic [1:0] reg_ep, // endpoint of the selected register
    output logic wr_pulse, // write takes effect this edge
    output logic rd_setup // capture read data this edge
);
    logic [17:0] idx;
    logic aligned;
    logic setup_hit;
    logic fifo_hit;
    logic hit;

    assign idx = paddr[uefc_pkg::ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup_hit = aligned
        && (idx[17:2] == uefc_pkg::IDX_SETUP_BASE[17:2]);
    assign fifo_hit = aligned
        && (idx[17:2] == uefc_pkg::IDX_FIFO_BASE[17:2]);
    assign hit = setup_hit || fifo_hit;
    assign reg_is_fifo = fifo_hit;
    assign reg_ep = idx[1:0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign wr_pulse = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite && hit;
endmodule : uefc_apb_decode
`default_nettype wire

// *** src/uefc_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop synchroniser per pin, then rising-edge pulse
module uefc_edge_sync (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic [uefc_pkg::NUM_EP-1:0] pin_in, // raw pins
    output logic [uefc_pkg::NUM_EP-1:0] rise_pulse // one-cycle pulse
);
    logic [uefc_pkg::NUM_EP-1:0] meta_reg;
    logic [uefc_pkg::NUM_EP-1:0] sync_reg;
    logic [uefc_pkg::NUM_EP-1:0] last_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise_pulse = sync_reg & ~last_reg;
endmodule : uefc_edge_sync
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] usb_traffic, ep_respond, ep_enable, ep_dir_in;
    logic [7:0] ep_type;
    logic [3:0] ep_type_invalid, ep_buf_1024, ep_buf_invalid;
    logic [11:0] ep_buf_count;
    logic [3:0] in_full_early_flag, out_empty_early_flag, auto_commit_out;
    logic [3:0] auto_commit_in, empty_packet_enable, sixteen_bit_select;
    logic [3:0] packet_end_strobe, in_pkt_empty, send_empty_packet;
    logic upper_port_is_fifo_data, e;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int cnt;
    logic [2:0] depth [4] = '{3'h4, 3'h0, 3'h2, 3'h3};
    uefc_ep_config_regs dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .usb_traffic(usb_traffic),
        .ep_respond(ep_respond), .ep_enable(ep_enable),
        .ep_dir_in(ep_dir_in), .ep_type(ep_type),
        .ep_type_invalid(ep_type_invalid), .ep_buf_1024(ep_buf_1024),
        .ep_buf_count(ep_buf_count), .ep_buf_invalid(ep_buf_invalid),
        .in_full_early_flag(in_full_early_flag),
        .out_empty_early_flag(out_empty_early_flag),
        .auto_commit_out(auto_commit_out), .auto_commit_in(auto_commit_in),
        .empty_packet_enable(empty_packet_enable),
        .sixteen_bit_select(sixteen_bit_select),
        .packet_end_strobe(packet_end_strobe), .in_pkt_empty(in_pkt_empty),
        .send_empty_packet(send_empty_packet),
        .upper_port_is_fifo_data(upper_port_is_fifo_data)
    );
    // ======================================================
    // clock, watchdog, verdict
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            bad_count++;
            results();
        end
    end
    task automatic results;
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    // ======================================================
    // apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [17:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [17:0] su(input int ep);
        return uefc_pkg::IDX_SETUP_BASE + 18'(ep);
    endfunction : su
    function automatic logic [17:0] fi(input int ep);
        return uefc_pkg::IDX_FIFO_BASE + 18'(ep);
    endfunction : fi
    // ======================================================
    // scenarios
    task automatic t_reset;
        chk(upper_port_is_fifo_data, 1);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, fi(i), 0);
            chk(q, 32'h05);
            apb(0, su(i), 0);
            chk(q, 32'hA2);
        end
        apb(0, 18'h00000, 0);
        chk(e, 1);
    endtask : t_reset
    task automatic t_size_dir;
        apb(1, su(0), 32'hFF);
        apb(0, su(0), 0);
        chk(q, 32'hFB);
        chk(ep_buf_1024[0], 1);
        chk(ep_dir_in[0], 1);
        apb(1, su(1), 32'hFF);
        apb(0, su(1), 0);
        chk(q, 32'hF3);
        chk(ep_buf_1024[1], 0);
        apb(1, su(1), 32'h22);
        chk(ep_respond, 4'hD);
        chk(ep_dir_in[1], 0);
    endtask : t_size_dir
    task automatic t_type_buf;
        for (int t = 0; t < 4; t++)
        begin
            apb(1, su(2), 32'h82 | (t << 4));
            chk(ep_type[5:4], t);
            chk(ep_type_invalid[2], t == 0);
        end
        for (int b = 0; b < 4; b++)
        begin
            apb(1, su(2), 32'hA0 | b);
            chk(ep_buf_count[8:6], depth[b]);
            chk(ep_buf_invalid[2], b == 1);
        end
    endtask : t_type_buf
    // pulse is counted on the falling edge, where it has settled
    task automatic pend(input logic [31:0] exp);
        cnt = 0;
        packet_end_strobe[0] <= 1'b1;
        repeat (10)
        begin
            @(negedge pclk);
            cnt += (send_empty_packet[0] === 1'b1);
        end
        @(posedge pclk);
        packet_end_strobe[0] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(cnt, exp);
    endtask : pend
    task automatic t_empty_pkt;
        apb(1, su(0), 32'hE2);
        pend(1);
        apb(1, fi(0), 32'h01);
        pend(0);
    endtask : t_empty_pkt
    task automatic t_wide;
        for (int i = 0; i < 4; i++)
            apb(1, fi(i), 32'h04);
        @(posedge pclk);
        chk(sixteen_bit_select, 0);
        chk(upper_port_is_fifo_data, 0);
        apb(1, fi(3), 32'hFF);
        @(posedge pclk);
        chk(upper_port_is_fifo_data, 1);
        apb(0, fi(3), 0);
        chk(q, 32'h7D);
        apb(1, fi(3), 32'h00);
        apb(1, fi(2), 32'h01);
        @(posedge pclk);
        chk(sixteen_bit_select, 4'h4);
        chk(upper_port_is_fifo_data, 1);
    endtask : t_wide
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        usb_traffic = 4'hF;
        packet_end_strobe = 4'h0;
        in_pkt_empty = 4'hF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_size_dir();
        t_type_buf();
        t_empty_pkt();
        t_wide();
        results();
    end
endmodule : testbench
`default_nettype wire
